// File: eufd_pkg.sv
// Package of field layouts, encodings and reset values for the instruction field decoder
package eufd_pkg;

  // ----------------------------------------
  // Field widths
  // ----------------------------------------
  localparam int DESC_W   = 31;
  localparam int COND_W   = 4;
  localparam int REG_W    = 8;
  localparam int SUB_W    = 5;
  localparam int ADDR_W   = 13;
  localparam int ARF_TYPE_W = 4;

  // ----------------------------------------
  // Opcode classes
  // ----------------------------------------
  localparam logic [2:0] CLS_ALU   = 3'h0;
  localparam logic [2:0] CLS_SEND  = 3'h1;
  localparam logic [2:0] CLS_SENDC = 3'h2;
  localparam logic [2:0] CLS_MATH  = 3'h3;
  localparam logic [2:0] CLS_CMP   = 3'h4;

  // ----------------------------------------
  // Register file select encodings
  // ----------------------------------------
  localparam logic [1:0] RF_ARF = 2'h0;
  localparam logic [1:0] RF_GRF = 2'h1;
  localparam logic [1:0] RF_MRF = 2'h2;
  localparam logic [1:0] RF_IMM = 2'h3;

  // ----------------------------------------
  // Register index limits
  // ----------------------------------------
  localparam logic [7:0] GRF_MAX = 8'h7F;
  localparam logic [7:0] MRF_MAX = 8'h0F;

  // ----------------------------------------
  // Flag update condition codes
  // ----------------------------------------
  localparam logic [3:0] FC_NONE = 4'h0;
  localparam logic [3:0] FC_Z    = 4'h1;
  localparam logic [3:0] FC_NZ   = 4'h2;
  localparam logic [3:0] FC_G    = 4'h3;
  localparam logic [3:0] FC_GE   = 4'h4;
  localparam logic [3:0] FC_L    = 4'h5;
  localparam logic [3:0] FC_LE   = 4'h6;
  localparam logic [3:0] FC_O    = 4'h8;
  localparam logic [3:0] FC_U    = 4'h9;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

endpackage

// File: eufd_operand_addr.sv
// Operand address former for one register operand
`timescale 1ns/1ps
module eufd_operand_addr
(
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         clk_en_i,
  input  wire logic                         load_i,
  input  wire logic [1:0]                   register_file_select_i,
  input  wire logic                         indirect_i,
  input  wire logic [eufd_pkg::REG_W-1:0]   register_index_i,
  input  wire logic [eufd_pkg::SUB_W-1:0]   subregister_offset_i,
  output logic      [eufd_pkg::ADDR_W-1:0]  byte_addr_o,
  output logic      [eufd_pkg::ARF_TYPE_W-1:0] arf_type_o,
  output logic      [eufd_pkg::ARF_TYPE_W-1:0] arf_number_o,
  output logic                              addr_valid_o,
  output logic                              reserved_o
);

  typedef struct packed {
    logic [eufd_pkg::ADDR_W-1:0]     addr;
    logic [eufd_pkg::ARF_TYPE_W-1:0] atype;
    logic [eufd_pkg::ARF_TYPE_W-1:0] anum;
    logic                            valid;
    logic                            rsvd;
  } eufd_oa_s;

  eufd_oa_s st_q;
  eufd_oa_s st_d;

  always_comb
  begin
    st_d = st_q;
    if (load_i)
    begin
      st_d.addr  = '0;
      st_d.atype = '0;
      st_d.anum  = '0;
      st_d.valid = 1'b0;
      st_d.rsvd  = 1'b0;
      if (register_file_select_i != eufd_pkg::RF_IMM && !indirect_i)
      begin
        st_d.valid = 1'b1;
        st_d.addr  = {register_index_i, subregister_offset_i};
        if (register_file_select_i == eufd_pkg::RF_ARF)
        begin
          st_d.atype = register_index_i[7:4];
          st_d.anum  = register_index_i[3:0];
        end
        if (register_file_select_i == eufd_pkg::RF_GRF)
          st_d.rsvd = register_index_i > eufd_pkg::GRF_MAX;
        if (register_file_select_i == eufd_pkg::RF_MRF)
          st_d.rsvd = register_index_i > eufd_pkg::MRF_MAX;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      st_q <= '0;
    else if (clk_en_i)
      st_q <= st_d;
  end

  assign byte_addr_o  = st_q.addr;
  assign arf_type_o   = st_q.atype;
  assign arf_number_o = st_q.anum;
  assign addr_valid_o = st_q.valid;
  assign reserved_o   = st_q.rsvd;

endmodule

// File: eufd_decoder.sv
// Execution unit instruction field decoder top
// Operation
// - Pass 31-bit message descriptor unchanged, only from message-send instructions.
// - End-of-thread set on send terminates thread and sets sideband bit.
// - Four-bit condition code selects which pipe condition updates the flag.
// - Condition code zero leaves every flag unchanged.
// - Instructions with embedded compare never update flags.
// - Condition code ignored for send, conditional send and math.
// - General and message index gives the 256-bit aligned register address.
// - Architecture index: upper bits type, lower bits number.
// - Byte origin is index in bits 12:5, offset in bits 4:0.
// - Index used for destination and sources, absent for immediate.
// - Index only present for direct addressing, not register-indirect.
// - General index 0x00-0x7F valid, 0x80-0xFF reserved.
// - Message index 0x00-0x0F valid, 0x10-0xFF reserved.
`timescale 1ns/1ps
module eufd_decoder
(
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         clk_en_i,
  input  wire logic                         instr_valid_i,
  input  wire logic [2:0]                   instr_class_i,
  input  wire logic [eufd_pkg::DESC_W-1:0]  msg_desc_i,
  input  wire logic                         end_of_thread_flag_i,
  input  wire logic [eufd_pkg::COND_W-1:0]  flag_update_condition_i,
  input  wire logic                         cond_zero_i,
  input  wire logic                         cond_sign_i,
  input  wire logic                         cond_overflow_i,
  input  wire logic                         cond_nan_i,
  input  wire logic [1:0]                   dst_rf_i,
  input  wire logic                         dst_indirect_i,
  input  wire logic [eufd_pkg::REG_W-1:0]   dst_index_i,
  input  wire logic [eufd_pkg::SUB_W-1:0]   dst_sub_i,
  input  wire logic [1:0]                   src_rf_i,
  input  wire logic                         src_indirect_i,
  input  wire logic [eufd_pkg::REG_W-1:0]   src_index_i,
  input  wire logic [eufd_pkg::SUB_W-1:0]   src_sub_i,
  output logic      [eufd_pkg::DESC_W-1:0]  msg_desc_o,
  output logic                              msg_valid_o,
  output logic                              sideband_eot_o,
  output logic                              thread_terminate_o,
  output logic                              flag_we_o,
  output logic                              flag_value_o,
  output logic                              cond_reserved_o,
  output logic      [eufd_pkg::ADDR_W-1:0]  dst_addr_o,
  output logic      [eufd_pkg::ARF_TYPE_W-1:0] dst_arf_type_o,
  output logic      [eufd_pkg::ARF_TYPE_W-1:0] dst_arf_number_o,
  output logic                              dst_valid_o,
  output logic                              dst_reserved_o,
  output logic      [eufd_pkg::ADDR_W-1:0]  src_addr_o,
  output logic      [eufd_pkg::ARF_TYPE_W-1:0] src_arf_type_o,
  output logic      [eufd_pkg::ARF_TYPE_W-1:0] src_arf_number_o,
  output logic                              src_valid_o,
  output logic                              src_reserved_o
);

  // ----------------------------------------
  // Condition evaluation
  // ----------------------------------------
  // Condition code table
  function automatic logic [1:0] eufd_cond_eval(input logic [3:0] code,
                                                input logic       z,
                                                input logic       s,
                                                input logic       o,
                                                input logic       n);
    logic [1:0] r;
    r = 2'h0;
    case (code)
      eufd_pkg::FC_Z:  r = {1'b0, z};
      eufd_pkg::FC_NZ: r = {1'b0, !z};
      eufd_pkg::FC_G:  r = {1'b0, !s && !z};
      eufd_pkg::FC_GE: r = {1'b0, !s};
      eufd_pkg::FC_L:  r = {1'b0, s && !z};
      eufd_pkg::FC_LE: r = {1'b0, s || z};
      eufd_pkg::FC_O:  r = {1'b0, o};
      eufd_pkg::FC_U:  r = {1'b0, n};
      eufd_pkg::FC_NONE: r = 2'h0;
      default:         r = 2'h2;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // Class decoding
  // ----------------------------------------
  // Message-send classes
  function automatic logic eufd_is_send(input logic [2:0] cls);
    return cls == eufd_pkg::CLS_SEND || cls == eufd_pkg::CLS_SENDC;
  endfunction

  function automatic logic eufd_flag_allowed(input logic [2:0] cls,
                                             input logic [3:0] code);
    logic ok;
    ok = 1'b1;
    if (eufd_is_send(cls) || cls == eufd_pkg::CLS_MATH)
      ok = 1'b0;
    if (cls == eufd_pkg::CLS_CMP)
      ok = 1'b0;
    if (code == eufd_pkg::FC_NONE)
      ok = 1'b0;
    return ok;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [eufd_pkg::DESC_W-1:0] desc;
    logic                        mvalid;
    logic                        end_of_thread_flag;
    logic                        term;
    logic                        fwe;
    logic                        fval;
    logic                        crsv;
  } eufd_st_s;

  eufd_st_s st_q;
  eufd_st_s st_d;
  logic     is_send;
  logic     honour;
  logic [1:0] ev;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    st_d    = st_q;
    is_send = eufd_is_send(instr_class_i);
    honour  = eufd_flag_allowed(instr_class_i, flag_update_condition_i);
    ev      = eufd_cond_eval(flag_update_condition_i, cond_zero_i, cond_sign_i,
                             cond_overflow_i, cond_nan_i);
    st_d.mvalid = 1'b0;
    st_d.end_of_thread_flag    = 1'b0;
    st_d.term   = 1'b0;
    st_d.fwe    = 1'b0;
    st_d.crsv   = 1'b0;
    if (instr_valid_i)
    begin
      if (is_send)
      begin
        st_d.desc   = msg_desc_i;
        st_d.mvalid = 1'b1;
        st_d.end_of_thread_flag    = end_of_thread_flag_i;
        st_d.term   = end_of_thread_flag_i;
      end
      if (honour)
      begin
        st_d.fwe  = !ev[1];
        st_d.fval = ev[0];
        st_d.crsv = ev[1];
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      st_q <= '0;
    else if (clk_en_i)
      st_q <= st_d;
  end

  // ----------------------------------------
  // Output drive
  // ----------------------------------------
  assign msg_desc_o         = st_q.desc;
  assign msg_valid_o        = st_q.mvalid;
  assign sideband_eot_o     = st_q.end_of_thread_flag;
  assign thread_terminate_o = st_q.term;
  assign flag_we_o          = st_q.fwe;
  assign flag_value_o       = st_q.fval;
  assign cond_reserved_o    = st_q.crsv;

  // ----------------------------------------
  // Operand addressing
  // ----------------------------------------
  // Destination register address
  eufd_operand_addr u_dst
  (
    .core_clk_i             (core_clk_i),
    .rst_i                  (rst_i),
    .clk_en_i               (clk_en_i),
    .load_i                 (instr_valid_i),
    .register_file_select_i (dst_rf_i),
    .indirect_i             (dst_indirect_i),
    .register_index_i       (dst_index_i),
    .subregister_offset_i   (dst_sub_i),
    .byte_addr_o            (dst_addr_o),
    .arf_type_o             (dst_arf_type_o),
    .arf_number_o           (dst_arf_number_o),
    .addr_valid_o           (dst_valid_o),
    .reserved_o             (dst_reserved_o)
  );

  eufd_operand_addr u_src
  (
    .core_clk_i             (core_clk_i),
    .rst_i                  (rst_i),
    .clk_en_i               (clk_en_i),
    .load_i                 (instr_valid_i),
    .register_file_select_i (src_rf_i),
    .indirect_i             (src_indirect_i),
    .register_index_i       (src_index_i),
    .subregister_offset_i   (src_sub_i),
    .byte_addr_o            (src_addr_o),
    .arf_type_o             (src_arf_type_o),
    .arf_number_o           (src_arf_number_o),
    .addr_valid_o           (src_valid_o),
    .reserved_o             (src_reserved_o)
  );

endmodule

// File: eufd_decoder_chk.sv
// Port assertions for the instruction field decoder
`timescale 1ns/1ps
module eufd_decoder_chk
(
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        clk_en_i,
  input wire logic        instr_valid_i,
  input wire logic [2:0]  instr_class_i,
  input wire logic [30:0] msg_desc_i,
  input wire logic        end_of_thread_flag_i,
  input wire logic [3:0]  flag_update_condition_i,
  input wire logic        cond_zero_i,
  input wire logic [1:0]  dst_rf_i,
  input wire logic        dst_indirect_i,
  input wire logic [7:0]  dst_index_i,
  input wire logic [4:0]  dst_sub_i,
  input wire logic [30:0] msg_desc_o,
  input wire logic        msg_valid_o,
  input wire logic        sideband_eot_o,
  input wire logic        thread_terminate_o,
  input wire logic        flag_we_o,
  input wire logic        flag_value_o,
  input wire logic [12:0] dst_addr_o,
  input wire logic        dst_valid_o,
  input wire logic        dst_reserved_o
);
  logic tk;
  logic snd;
  logic general_register_file;
  assign tk = clk_en_i && instr_valid_i;
  assign snd = tk && instr_class_i == 3'h1;
  assign general_register_file = tk && dst_rf_i == 2'h1 && !dst_indirect_i;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  property p_desc; snd |=> msg_valid_o && msg_desc_o == $past(msg_desc_i); endproperty
  a_desc: assert property (p_desc) else $error("descriptor lost");
  property p_end; snd |=> sideband_eot_o == $past(end_of_thread_flag_i)
    && thread_terminate_o == sideband_eot_o; endproperty
  a_end: assert property (p_end) else $error("thread end wrong");
  property p_zf; tk && instr_class_i == 3'h0 && flag_update_condition_i == 4'h1
    |=> flag_we_o && flag_value_o == $past(cond_zero_i); endproperty
  a_zf: assert property (p_zf) else $error("zero flag wrong");
  property p_none; tk && flag_update_condition_i == 4'h0 |=> !flag_we_o; endproperty
  a_none: assert property (p_none) else $error("flag written on code zero");
  property p_cmp; tk && instr_class_i == 3'h4 |=> !flag_we_o; endproperty
  a_cmp: assert property (p_cmp) else $error("flag written on compare");
  property p_skip; tk && instr_class_i inside {3'h1, 3'h2, 3'h3} |=> !flag_we_o; endproperty
  a_skip: assert property (p_skip) else $error("flag written on send or math");
  property p_addr; general_register_file |=> dst_valid_o
    && dst_addr_o == {$past(dst_index_i), $past(dst_sub_i)}; endproperty
  a_addr: assert property (p_addr) else $error("operand address wrong");
  property p_grf; general_register_file |=> dst_reserved_o == ($past(dst_index_i) > 8'h7F); endproperty
  a_grf: assert property (p_grf) else $error("general index range wrong");
endmodule
bind eufd_decoder eufd_decoder_chk eufd_decoder_chk_i (.*);

// File: eufd_msg_sink.sv
// Message sink standing for the shared function units
`timescale 1ns/1ps
module eufd_msg_sink
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       msg_valid_i,
  input  wire logic       end_of_thread_i,
  output logic      [7:0] msg_count_o,
  output logic      [7:0] end_count_o
);
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      msg_count_o <= 8'h00;
      end_count_o <= 8'h00;
    end
    else if (msg_valid_i)
    begin
      msg_count_o <= msg_count_o + 8'h01;
      end_count_o <= end_count_o + {7'h00, end_of_thread_i};
    end
  end
endmodule

// File: tb_top.sv
// Self-checking testbench for the instruction field decoder
`timescale 1ns/1ps
module tb_top;
  logic        core_clk_i, rst_i, clk_en_i, instr_valid_i, end_of_thread_flag_i;
  logic        cond_zero_i, cond_sign_i, cond_overflow_i, cond_nan_i, dst_indirect_i;
  logic        src_indirect_i, msg_valid_o, sideband_eot_o, thread_terminate_o, flag_we_o;
  logic        flag_value_o, cond_reserved_o, dst_valid_o, dst_reserved_o;
  logic        src_valid_o, src_reserved_o;
  logic [2:0]  instr_class_i;
  logic [30:0] msg_desc_i, msg_desc_o;
  logic [3:0]  flag_update_condition_i, dst_arf_type_o, dst_arf_number_o;
  logic [3:0]  src_arf_type_o, src_arf_number_o;
  logic [1:0]  dst_rf_i, src_rf_i;
  logic [7:0]  dst_index_i, src_index_i, msg_count, end_count;
  logic [4:0]  dst_sub_i, src_sub_i;
  logic [12:0] dst_addr_o, src_addr_o;
  logic [11:0] rows [24];
  int          bad_count, tests_run, i;
  eufd_decoder eufd_decoder_i (.*);
  eufd_msg_sink eufd_msg_sink_i (.core_clk_i, .rst_i, .msg_valid_i(msg_valid_o),
    .end_of_thread_i(sideband_eot_o), .msg_count_o(msg_count), .end_count_o(end_count));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task issue(input logic [2:0] c, input logic [3:0] f, input logic [3:0] z);
    @(posedge core_clk_i);
    instr_class_i <= c;
    flag_update_condition_i <= f;
    {cond_zero_i, cond_sign_i, cond_overflow_i, cond_nan_i} <= z;
    instr_valid_i <= 1'b1;
    @(posedge core_clk_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask
  task snd(input logic [2:0] c, input logic e, input logic [30:0] d);
    @(posedge core_clk_i);
    end_of_thread_flag_i <= e;
    msg_desc_i <= d;
    issue(c, 4'h0, 4'h0);
  endtask
  task opnd(input logic [1:0] rf, input logic ind, input logic [7:0] x, input logic [4:0] s,
            input logic [12:0] a, input logic v, input logic r);
    @(posedge core_clk_i);
    {dst_rf_i, dst_indirect_i, dst_index_i, dst_sub_i} <= {rf, ind, x, s};
    {src_rf_i, src_indirect_i, src_index_i, src_sub_i} <= {rf, ind, x, s};
    issue(3'h0, 4'h0, 4'h0);
    chk("addr", 32'({a, a}), 32'({dst_addr_o, src_addr_o}));
    chk("valid", 32'({v, v}), 32'({dst_valid_o, src_valid_o}));
    chk("reserved", 32'({r, r}), 32'({dst_reserved_o, src_reserved_o}));
  endtask
  initial
  begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  initial
  begin
    repeat (3000) @(posedge core_clk_i);
    bad_count++;
    test_done;
  end
  initial
  begin
    {rst_i, clk_en_i, instr_valid_i, end_of_thread_flag_i, instr_class_i} = 7'h60;
    {cond_zero_i, cond_sign_i, cond_overflow_i, cond_nan_i, flag_update_condition_i} = 8'h00;
    {msg_desc_i, dst_indirect_i, src_indirect_i, dst_rf_i, src_rf_i} = 37'h0;
    {dst_index_i, src_index_i, dst_sub_i, src_sub_i} = 26'h0;
    bad_count = 0;
    tests_run = 0;
    rows = '{12'h0F0, 12'h186, 12'h104, 12'h284, 12'h206, 12'h306, 12'h384, 12'h486,
             12'h444, 12'h546, 12'h5C4, 12'h6C6, 12'h604, 12'h826, 12'h8D4, 12'h916,
             12'h9E4, 12'h7F1, 12'hAF1, 12'hBF1, 12'hCF1, 12'hDF1, 12'hEF1, 12'hFF1};
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1;
    chk("reset", 32'h0, 32'({msg_desc_o, msg_valid_o}));
    for (i = 0; i < 24; i++)
    begin
      issue(3'h0, rows[i][11:8], rows[i][7:4]);
      chk("flag_we", 32'(rows[i][2]), 32'(flag_we_o));
      chk("cond_reserved", 32'(rows[i][0]), 32'(cond_reserved_o));
      if (rows[i][2])
        chk("flag_value", 32'(rows[i][1]), 32'(flag_value_o));
    end
    for (i = 1; i < 5; i++)
    begin
      issue(3'(i), 4'h1, 4'h8);
      chk("flag_we", 32'h0, 32'(flag_we_o));
      issue(3'(i), 4'hF, 4'h0);
      chk("cond_reserved", 32'h0, 32'(cond_reserved_o));
    end
    snd(3'h1, 1'b1, 31'h5A5A_1234);
    chk("send", 32'hDA5A_1234, {msg_valid_o, msg_desc_o});
    chk("thread_end", 32'h3, 32'({sideband_eot_o, thread_terminate_o}));
    snd(3'h0, 1'b1, 31'h0123_4567);
    chk("held", 32'h5A5A_1234, {msg_valid_o, msg_desc_o});
    chk("thread_end", 32'h0, 32'({sideband_eot_o, thread_terminate_o}));
    snd(3'h1, 1'b0, 31'h7FFF_FFFF);
    chk("thread_end", 32'h0, 32'({sideband_eot_o, thread_terminate_o}));
    opnd(2'h1, 1'b0, 8'h7F, 5'h1F, 13'h0FFF, 1'b1, 1'b0);
    opnd(2'h1, 1'b0, 8'h80, 5'h00, 13'h1000, 1'b1, 1'b1);
    opnd(2'h2, 1'b0, 8'h0F, 5'h03, 13'h01E3, 1'b1, 1'b0);
    opnd(2'h2, 1'b0, 8'h10, 5'h00, 13'h0200, 1'b1, 1'b1);
    opnd(2'h0, 1'b0, 8'hA5, 5'h02, 13'h14A2, 1'b1, 1'b0);
    chk("arf", 32'hA5, 32'({dst_arf_type_o, dst_arf_number_o}));
    chk("src_arf", 32'hA5, 32'({src_arf_type_o, src_arf_number_o}));
    opnd(2'h3, 1'b0, 8'h12, 5'h04, 13'h0000, 1'b0, 1'b0);
    chk("dst_arf_clear", 32'h0, 32'({dst_arf_type_o, dst_arf_number_o}));
    chk("src_arf_clear", 32'h0, 32'({src_arf_type_o, src_arf_number_o}));
    opnd(2'h1, 1'b1, 8'h12, 5'h04, 13'h0000, 1'b0, 1'b0);
    @(posedge core_clk_i);
    clk_en_i <= 1'b0;
    snd(3'h1, 1'b1, 31'h1);
    chk("frozen", 32'h7FFF_FFFF, {msg_valid_o, msg_desc_o});
    @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    chk("msg_count", 32'h0601, 32'({msg_count, end_count}));
    snd(3'h1, 1'b1, 31'h1);
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1;
    chk("reset", 32'h0, {msg_desc_o, sideband_eot_o});
    test_done;
  end
endmodule
